// ===== src/sink_driver_pkg.sv
// Shared constants for the serial-in latched sink driver
package sink_driver_pkg;
    localparam int CHAIN_LEN = 16;
    localparam logic [15:0] STAGE_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [15:0] SINK_ALL_OFF = 16'h0000;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_COUNT_RESET = 2'h0;
endpackage

// ===== src/word_buffer.sv
// Two-entry valid/ready buffer for the parallel word path
`timescale 1ns/1ns
module word_buffer (
    input wire logic sys_clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic inValid, // Word offered
    output logic inReady, // Room for a word
    input wire logic [15:0] inData, // Offered word
    output logic outValid, // Word available
    input wire logic outReady, // Receiver takes word
    output logic [15:0] outData // Head word, registered
);
    logic [15:0] slot0;
    logic [15:0] slot1;
    logic [1:0] count;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = (count != 2'(sink_driver_pkg::BUF_DEPTH));
    assign outValid = (count != 2'h0);
    assign outData = slot0;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= sink_driver_pkg::BUF_COUNT_RESET;
            slot0 <= sink_driver_pkg::LATCH_RESET;
            slot1 <= sink_driver_pkg::LATCH_RESET;
        end else begin
            count <= count + 2'(push) - 2'(pop);
            if (pop) begin
                slot0 <= (count == 2'h2) ? slot1 : inData;
            end else if (push && count == 2'h0) begin
                slot0 <= inData;
            end
            if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
                slot1 <= inData;
            end
        end
    end

    // Full and stalled: both queued words must stand untouched
    chk_buf_no_overflow: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
        count == 2'h2 && !outReady |=> count == 2'h2 && $stable(slot0) && $stable(slot1))
        else $error("buffer lost a word while full");
endmodule

// ===== src/serial_in_latched_sink_driver.sv
// Serial-in shift chain with transfer latches driving 16 sink outputs
// Contract
// [RULE1] Each rising shift edge moves chain one place; first stage takes serial input.
// [RULE2] Strobe and output-off low: sinks follow shift stages directly (here via latch and two-entry buffer, only while sinkReady high).
// [RULE3] Strobe high, output-off low: sinks hold last valid state.
// [RULE4] Output-off high turns all 16 sinks off.
// [RULE5] Strobe and output-off are levels, never edge triggered.
// [RULE6] Strobe high loads master stages; strobe low copies them to latches.
// [RULE7] Serial output lets devices chain into longer words.
// [RULE8] Output-off never alters stored shift or latch contents.
// [RULE9] Serial output is last stage, updated after each rising shift edge.
`timescale 1ns/1ns
module serial_in_latched_sink_driver (
    input wire logic sys_clk, // System clock, 50 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic shiftClk, // Host shift clock, sampled
    input wire logic serialIn, // Serial data in
    input wire logic strobe, // Latch-transfer strobe, high holds
    input wire logic outputOff, // Output-off control, high disables
    input wire logic sinkReady, // Sink stage accepts the word
    output logic [15:0] sinkOn, // One per sink, high = transistor on
    output logic serialOut // Serial data out for chaining
);
    // ------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------
    logic shiftPrev;
    logic [15:0] stages;
    logic [15:0] latched;
    wire shiftEdge = shiftClk && !shiftPrev;
    wire [15:0] next_stages = {stages[14:0], serialIn};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shiftPrev <= 1'b0;
            stages <= sink_driver_pkg::STAGE_RESET;
        end else begin
            shiftPrev <= shiftClk;
            if (shiftEdge) begin
                stages <= next_stages; // RULE1 RULE6 RULE8
            end
        end
    end

    // Stage 15 is the chain's tail; registered so it changes after the edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            serialOut <= 1'b0;
        end else begin
            serialOut <= stages[15]; // RULE7 RULE9
        end
    end

    // ------------------------------------------------------------
    // Transfer latch
    // ------------------------------------------------------------
    // Transparent while strobe low, frozen while high; levels only.
    wire [15:0] next_latched = strobe ? latched : stages; // RULE2 RULE3 RULE5 RULE6

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            latched <= sink_driver_pkg::LATCH_RESET;
        end else begin
            latched <= next_latched; // RULE8
        end
    end

    // ------------------------------------------------------------
    // Output buffer and gate
    // ------------------------------------------------------------
    // A stalled sink stage keeps the two oldest words queued; while full, only the current latched word waits to enter.
    logic bufValid;
    logic [15:0] bufData;
    logic bufInReady;
    logic [15:0] lastSent;
    wire changed = (latched != lastSent);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lastSent <= sink_driver_pkg::LATCH_RESET;
        end else if (changed && bufInReady) begin
            lastSent <= latched;
        end
    end

    word_buffer u_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .inValid(changed),
        .inReady(bufInReady),
        .inData(latched),
        .outValid(bufValid),
        .outReady(sinkReady),
        .outData(bufData)
    );

    logic [15:0] shown;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shown <= sink_driver_pkg::LATCH_RESET;
        end else if (bufValid && sinkReady) begin
            shown <= bufData;
        end
    end

    wire [15:0] next_sinkOn = outputOff ? sink_driver_pkg::SINK_ALL_OFF : shown; // RULE4 RULE5

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sinkOn <= sink_driver_pkg::SINK_ALL_OFF;
        end else begin
            sinkOn <= next_sinkOn;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence shift_seen;
        shiftEdge;
    endsequence

    chk_shift_moves_chain: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
        shift_seen |=> stages == {$past(stages[14:0]), $past(serialIn)})
        else $error("chain did not shift");
    chk_chain_holds_still: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
        !shiftEdge |=> $stable(stages)) else $error("chain moved without edge");
    chk_latch_follows: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
        !strobe |=> latched == $past(stages)) else $error("latch not transparent");
    chk_latch_holds: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
        strobe |=> $stable(latched)) else $error("latch changed under strobe");
    chk_off_forces: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
        outputOff |=> sinkOn == 16'h0000) else $error("sinks on while off");
    chk_off_keeps_data: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
        outputOff && !shiftEdge && strobe |=> $stable(stages) && $stable(latched))
        else $error("output-off disturbed stored data");
    chk_enable_resumes: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
        !outputOff |=> sinkOn == $past(shown)) else $error("sinks do not show stored word");
    chk_serial_tail: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9
        shift_seen ##1 1'b1 |=> serialOut == $past(stages[15])) else $error("serial out wrong");
    chk_level_strobe: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
        !strobe [*2] |=> latched == $past(stages)) else $error("strobe treated as edge");

    // ------------------------------------------------------------
    // Path checks
    // ------------------------------------------------------------
    sequence open_path;
        (!strobe && !outputOff && sinkReady && !shiftEdge) [*6];
    endsequence

    sequence strobe_fall;
        $fell(strobe);
    endsequence

    // Six quiet cycles drain any backlog, so sinks show the chain
    chk_sinks_follow: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
        open_path |=> sinkOn == $past(stages))
        else $error("sinks do not follow chain");

    // Strobe falling copies the whole chain at once
    chk_transfer_fall: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
        strobe_fall |=> latched == $past(stages))
        else $error("strobe fall did not transfer");

    // A shift under strobe must not reach the latches
    chk_strobe_blocks: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
        strobe && shiftEdge |=> $stable(latched))
        else $error("shift leaked through strobe");

    // Output-off must not stop the chain from shifting
    chk_off_shifts: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
        outputOff && shiftEdge |=> stages == {$past(stages[14:0]), $past(serialIn)})
        else $error("chain blocked while off");

    // Sinks come back with the stored word after output-off falls
    chk_off_release: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
        $fell(outputOff) |=> sinkOn == $past(shown))
        else $error("stored word lost after off");

    // Output-off acts on the very next edge
    chk_off_next_edge: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
        $rose(outputOff) |=> sinkOn == sink_driver_pkg::SINK_ALL_OFF)
        else $error("sinks slow to turn off");

    // Tail unchanged means serial output unchanged
    chk_serial_steady: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9
        $stable(stages[15]) |=> $stable(serialOut))
        else $error("serial out moved without tail");

    // Every accepted word is remembered as the last one sent
    chk_word_pushed: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
        changed && bufInReady |=> lastSent == $past(latched))
        else $error("pushed word not recorded");

    // Without a push the record stands
    chk_record_holds: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
        !(changed && bufInReady) |=> $stable(lastSent))
        else $error("record changed without push");

    // The head word is taken when the sink stage accepts
    chk_shown_takes: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
        bufValid && sinkReady |=> shown == $past(bufData))
        else $error("accepted word not shown");

    // A stalled sink stage keeps its word
    chk_shown_stalls: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
        bufValid && !sinkReady |=> $stable(shown))
        else $error("shown word changed during stall");

    // Nothing offered, nothing shown anew
    chk_shown_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
        !bufValid |=> $stable(shown))
        else $error("shown word changed while idle");

    // Reset leaves every sink off
    chk_reset_sinks: assert property (@(posedge sys_clk) // RULE4
        sys_rst |=> sinkOn == sink_driver_pkg::SINK_ALL_OFF)
        else $error("sinks on after reset");

    // Reset leaves the chaining output low
    chk_reset_serial: assert property (@(posedge sys_clk) // RULE9
        sys_rst |=> !serialOut)
        else $error("serial out high after reset");
endmodule

// ===== bench/host_model.sv
// Host port model that shifts one 16-bit word into the driver
`timescale 1ns/1ns
module host_model (
    input wire logic sys_clk, // System clock
    input wire logic go, // Start one word
    input wire logic [15:0] word, // Word to send, bit15 first
    output logic shiftClk, // Shift clock to the driver
    output logic serialIn, // Serial data to the driver
    output logic busy // Word in progress
);
    initial begin
        shiftClk = 1'b0;
        serialIn = 1'b0;
        busy = 1'b0;
        forever begin
            @(negedge sys_clk);
            if (go) begin
                busy = 1'b1;
                for (int i = 15; i >= 0; i--) begin
                    serialIn = word[i];
                    shiftClk = 1'b0;
                    @(negedge sys_clk);
                    shiftClk = 1'b1;
                    @(negedge sys_clk);
                end
                // Clock stands low between words; data no longer valid
                shiftClk = 1'b0;
                serialIn = ~serialIn;
                busy = 1'b0;
            end
        end
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the serial-in latched sink driver
`timescale 1ns/1ns
module testbench;
    logic sys_clk, sys_rst, go, strobe, outputOff, sinkReady, shiftClk, serialIn, busy, serialOut;
    logic [15:0] word, sinkOn;
    int err_count, cmp_count;
    serial_in_latched_sink_driver dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .shiftClk(shiftClk), .serialIn(serialIn), .strobe(strobe), .outputOff(outputOff),
        .sinkReady(sinkReady), .sinkOn(sinkOn), .serialOut(serialOut));
    host_model host (.sys_clk(sys_clk), .go(go), .word(word), .shiftClk(shiftClk),
        .serialIn(serialIn), .busy(busy));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, want);
        end
    endtask
    task automatic send(input logic [15:0] w);
        word <= w;
        go <= 1'b1;
        @(negedge sys_clk);
        go <= 1'b0;
        for (int i = 0; i < 80 && (i < 2 || busy); i++) @(negedge sys_clk);
        // Covers the five-edge path from last shift to sinkOn
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic results;
        $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic follow_test;
        send(16'hA5C3);
        check(sinkOn, 16'hA5C3);
        check({15'h0000, serialOut}, 16'h0001);
    endtask
    task automatic hold_test;
        strobe <= 1'b1;
        send(16'h3C5A);
        check(sinkOn, 16'hA5C3);
        check({15'h0000, serialOut}, 16'h0000);
        // Receiver stalls: the new word must wait, not be lost
        sinkReady <= 1'b0;
        strobe <= 1'b0;
        repeat (8) @(negedge sys_clk);
        check(sinkOn, 16'hA5C3);
        sinkReady <= 1'b1;
        repeat (8) @(negedge sys_clk);
        check(sinkOn, 16'h3C5A);
    endtask
    task automatic off_test;
        outputOff <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check(sinkOn, sink_driver_pkg::SINK_ALL_OFF);
        strobe <= 1'b1;
        repeat (4) @(negedge sys_clk);
        strobe <= 1'b0;
        repeat (6) @(negedge sys_clk);
        check(sinkOn, sink_driver_pkg::SINK_ALL_OFF);
        outputOff <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check(sinkOn, 16'h3C5A);
    endtask
    initial begin
        sys_rst = 1'b1;
        go = 1'b0;
        word = 16'h0000;
        strobe = 1'b0;
        outputOff = 1'b0;
        sinkReady = 1'b1;
        err_count = 0;
        cmp_count = 0;
        repeat (16) @(negedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check(sinkOn, sink_driver_pkg::SINK_ALL_OFF);
        check({15'h0000, serialOut}, 16'h0000);
        follow_test();
        hold_test();
        off_test();
        results();
    end
    // Whole run needs about 135 cycles; allow far more
    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule
